// ---- include/lsb_if.sv ----
// interface: link lanes and sideband wires between the two ends
`timescale 1ns/1ps
interface lsb_if #(parameter int LANES = lsb_pkg::DEF_LANES);
  localparam int SUBS = (LANES + lsb_pkg::SUBLINK_LANES - 1) / lsb_pkg::SUBLINK_LANES;
  logic [SUBS-1:0]  link_clk;          // one forwarded clock per byte
  logic [LANES-1:0] cmd_addr_data_lanes;
  logic [SUBS-1:0]  control_flag_lane;
  // open-drain sideband drives: value, enable (low = driving)
  logic power_good;        // from system
  logic link_stop_n;       // single driver: system
  logic dev_rst_o;  logic dev_rst_oe_n;   // device may only pull low
  logic dev_pg_o;   logic dev_pg_oe_n;
  logic dev_req_o;  logic dev_req_oe_n;
  logic sys_req_o;  logic sys_req_oe_n;
  logic sys_rst_o;  logic sys_rst_oe_n;
  // wired results
  wire chain_reset_n  = sys_rst_oe_n ? (dev_rst_oe_n ? 1'b1 : dev_rst_o) : (sys_rst_o & (dev_rst_oe_n | dev_rst_o));
  wire power_good_w   = power_good & (dev_pg_oe_n | dev_pg_o);
  wire link_request_n = (dev_req_oe_n | dev_req_o) & (sys_req_oe_n | sys_req_o);
  modport device (input link_clk, cmd_addr_data_lanes, control_flag_lane, power_good_w, chain_reset_n,
                  link_stop_n, link_request_n,
                  output dev_rst_o, dev_rst_oe_n, dev_pg_o, dev_pg_oe_n, dev_req_o, dev_req_oe_n);
  modport peer (output link_clk, cmd_addr_data_lanes, control_flag_lane, power_good, link_stop_n,
                sys_req_o, sys_req_oe_n, sys_rst_o, sys_rst_oe_n,
                input link_request_n, chain_reset_n, power_good_w);
endinterface

// ---- include/lsb_pkg.sv ----
// package: shared constants and types for the link sideband block
package lsb_pkg;
  // ****************************************
  // lane structure
  // ****************************************
  localparam int SUBLINK_LANES   = 8;     // lanes per sublink
  localparam int MAX_LANES       = 32;    // widest ganged link
  localparam int MAX_SUBLINKS    = 4;     // sublinks at widest
  localparam int DEF_LANES       = 8;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_PS   = 5000;  // core clock 200 MHz
  localparam int DEBOUNCE_NS     = 1000;  // least stable time of a sideband
  localparam int DEBOUNCE_CYC    = (DEBOUNCE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LINK_DIV        = 8;     // peer link clock divider (half period)
  localparam int DB_W            = 8;     // debounce counter width
  // ****************************************
  // reset classes
  // ****************************************
  typedef enum logic [1:0] {
    LSB_RST_NONE = 2'h0,
    LSB_RST_COLD = 2'h1,
    LSB_RST_WARM = 2'h2
  } lsb_rst_t;
  typedef enum logic [3:0] {
    LSB_OFF   = 4'h1,   // power not good
    LSB_RESET = 4'h2,   // chain reset held
    LSB_STOP  = 4'h4,   // link stopped
    LSB_RUN   = 4'h8    // link operating
  } lsb_state_t;
endpackage

// ---- rtl/lsb_device.sv ----
// device end: sideband conditioning, reset classing and lane receive
`timescale 1ns/1ps
// How it works
// - two bits per lane each link clock
// - lane group 2,4,8,16 or 32 wide
// - control lane per byte, or one
// - every byte has its own clock
// - wide links gang 8-lane sublinks
// - sublink: 8 lanes, flag, clock
// - power good, chain reset sequence links
// - first generation may only pull low
// - system feeds common sidebands to all
// - link request is wired-OR open drain
// - one driver of link stop
// - debounce all four sideband inputs
// - reset without power good is cold
// - reset from stop or run is warm
// - link held until power good
// - link stop disables, release re-enables
// - request low means link wanted
// - power and reset outrank link stop
// - stop released before chain reset
module lsb_device
  import lsb_pkg::*;
#(
  parameter int LANES     = DEF_LANES,
  parameter int DB_CYCLES = DEBOUNCE_CYC
) (
  input  wire logic               CLK,
  input  wire logic               RST_N,
  lsb_if.device                   LINK,
  input  wire logic               THIRD_GENERATION,          // third_generation protocol
  input  wire logic               PULL_RESET,    // first_generation pull of chain reset
  input  wire logic               PULL_PG,       // first_generation pull of power good
  input  wire logic               REQUEST,       // ask for link bring-up
  output logic                    LINK_ENABLE,
  output logic                    LINK_REQ_SEEN,
  output lsb_rst_t                RESET_CLASS,
  output lsb_state_t              STATE,
  output logic [2*LANES-1:0]      RX_DATA,       // two bit-times per lane
  output logic [1:0]              RX_FLAGS,      // control flag, both edges, lane 0
  output logic                    RX_VALID       // one-cycle pulse per captured word
);
  localparam int SUBS = (LANES + SUBLINK_LANES - 1) / SUBLINK_LANES;
  localparam int SL   = 4;

  // ****************************************
  // synchronise and debounce sidebands
  // ****************************************
  logic [SL-1:0] raw;
  logic [SL-1:0] clean;
  assign raw = {LINK.link_request_n, LINK.link_stop_n, LINK.chain_reset_n, LINK.power_good_w};

  genvar g;
  generate
    for (g = 0; g < SL; g++) begin : g_sb
      logic            s1;
      logic            s2;
      logic [DB_W-1:0] cnt;
      logic            st;
      // request idles high, so it starts released: no false request after reset
      localparam logic INIT = (g == SL - 1) ? 1'b1 : 1'b0;
      // two-stage synchroniser then stable counter
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          s1  <= INIT;
          s2  <= INIT;
          cnt <= '0;
          st  <= INIT;
        end else begin
          s1 <= raw[g];
          s2 <= s1;
          if (s2 == st) begin
            cnt <= '0;
          end else if (cnt == DB_W'(DB_CYCLES - 1)) begin
            st  <= s2;
            cnt <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
      end
      assign clean[g] = st;
    end
  endgenerate

  wire pg_ok   = clean[0];
  wire rst_act = ~clean[1];
  wire stop    = ~clean[2];
  wire req     = ~clean[3];

  // ****************************************
  // sideband state resolution
  // ****************************************
  lsb_state_t state;
  lsb_state_t next_state;
  lsb_rst_t   rclass;
  lsb_rst_t   next_rclass;

  // power and reset outrank stop
  always_comb begin
    next_rclass = rclass;
    case (1'b1)
      !pg_ok:  next_state = LSB_OFF;
      rst_act: next_state = LSB_RESET;
      stop:    next_state = LSB_STOP;
      default: next_state = LSB_RUN;
    endcase
    if (rst_act && !pg_ok) begin
      next_rclass = LSB_RST_COLD;
    end else if (rst_act && state != LSB_RESET && state != LSB_OFF) begin
      next_rclass = LSB_RST_WARM;
    end else if (rst_act && state == LSB_OFF) begin
      next_rclass = LSB_RST_COLD;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state  <= LSB_OFF;
      rclass <= LSB_RST_NONE;
    end else begin
      state  <= next_state;
      rclass <= next_rclass;
    end
  end

  assign STATE         = state;
  assign RESET_CLASS   = rclass;
  assign LINK_ENABLE   = (state == LSB_RUN);
  assign LINK_REQ_SEEN = req;

  // ****************************************
  // open-drain pulls, never high
  // ****************************************
  assign LINK.dev_rst_o    = 1'b0;
  assign LINK.dev_rst_oe_n = ~(PULL_RESET & ~THIRD_GENERATION);
  assign LINK.dev_pg_o     = 1'b0;
  assign LINK.dev_pg_oe_n  = ~(PULL_PG & ~THIRD_GENERATION);
  assign LINK.dev_req_o    = 1'b0;
  assign LINK.dev_req_oe_n = ~REQUEST;

  // ****************************************
  // link receive, per-sublink clock domain
  // ****************************************
  logic [SUBS-1:0] tog_link;
  logic [2*LANES-1:0] cap_rise_fall;
  logic [1:0]         flag_cap;

  generate
    for (g = 0; g < SUBS; g++) begin : g_sub
      localparam int W = (LANES < SUBLINK_LANES) ? LANES : SUBLINK_LANES;
      logic [W-1:0] rise;
      logic [W-1:0] word;
      logic [W-1:0] fall;
      logic         frise;
      logic [1:0]   fword;
      logic         tog;
      logic         en_s1;
      logic         en_s2;
      // first half of the bit pair on rising edge
      always_ff @(posedge LINK.link_clk[g] or negedge RST_N) begin
        if (!RST_N) begin
          rise  <= '0;
          frise <= 1'b0;
          en_s1 <= 1'b0;
        end else begin
          rise  <= LINK.cmd_addr_data_lanes[g*W +: W];
          frise <= LINK.control_flag_lane[THIRD_GENERATION ? g : 0];
          en_s1 <= LINK_ENABLE;
        end
      end
      // second half on falling edge, word held in flops and handed over by toggle
      always_ff @(negedge LINK.link_clk[g] or negedge RST_N) begin
        if (!RST_N) begin
          word  <= '0;
          fall  <= '0;
          fword <= '0;
          tog   <= 1'b0;
          en_s2 <= 1'b0;
        end else begin
          en_s2 <= en_s1;
          if (en_s2) begin
            word  <= rise;
            fall  <= LINK.cmd_addr_data_lanes[g*W +: W];
            fword <= {frise, LINK.control_flag_lane[THIRD_GENERATION ? g : 0]};
            tog   <= ~tog;
          end
        end
      end
      assign tog_link[g] = tog;
      assign cap_rise_fall[2*g*W +: 2*W] = {word, fall};
      if (g == 0) begin : g_f
        assign flag_cap = fword;
      end
    end
  endgenerate

  // toggle crossing of sublink 0 (ganged sublinks run in step)
  logic t1;
  logic t2;
  logic t3;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      t1       <= 1'b0;
      t2       <= 1'b0;
      t3       <= 1'b0;
      RX_DATA  <= '0;
      RX_FLAGS <= '0;
      RX_VALID <= 1'b0;
    end else begin
      t1       <= tog_link[0];
      t2       <= t1;
      t3       <= t2;
      RX_VALID <= (t2 ^ t3) & LINK_ENABLE;
      if (t2 ^ t3) begin
        RX_DATA  <= cap_rise_fall;
        RX_FLAGS <= flag_cap;
      end
    end
  end
endmodule // lsb_device

// ---- rtl/lsb_peer.sv ----
// peer end: system sideband driver and link transmitter
`timescale 1ns/1ps
module lsb_peer
  import lsb_pkg::*;
#(
  parameter int LANES = DEF_LANES,
  parameter int DIV   = LINK_DIV
) (
  input  wire logic               CLK,
  input  wire logic               RST_N,
  lsb_if.peer                     LINK,
  input  wire logic               THIRD_GENERATION,
  input  wire logic               POWER_GOOD,     // system power good
  input  wire logic               CHAIN_RESET,    // assert chain reset
  input  wire logic               STOP,           // ask link stop
  input  wire logic               REQUEST,        // ask link bring-up
  input  wire logic [2*LANES-1:0] TX_DATA,        // two bit-times per lane
  input  wire logic [1:0]         TX_FLAGS,
  output logic                    TX_READY,       // pulse: word taken
  output logic                    REQ_SEEN
);
  localparam int SUBS = (LANES + SUBLINK_LANES - 1) / SUBLINK_LANES;

  // ****************************************
  // sideband drive
  // ****************************************
  logic stop_q;
  logic rst_q;
  logic r1;
  logic r2;
  // stop released before chain reset
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      stop_q <= 1'b1;
      rst_q  <= 1'b1;
      r1     <= 1'b1;
      r2     <= 1'b1;
    end else begin
      stop_q <= STOP | (CHAIN_RESET & stop_q);
      rst_q  <= CHAIN_RESET | (rst_q & stop_q);
      r1     <= LINK.link_request_n;
      r2     <= r1;
    end
  end
  assign LINK.power_good   = POWER_GOOD;
  assign LINK.link_stop_n  = ~stop_q;
  assign LINK.sys_rst_o    = ~rst_q;
  assign LINK.sys_rst_oe_n = 1'b0;
  assign LINK.sys_req_o    = 1'b0;
  assign LINK.sys_req_oe_n = ~REQUEST;
  assign REQ_SEEN          = ~r2;

  // ****************************************
  // forwarded clock and lane drive
  // ****************************************
  logic [7:0]          div;
  logic                lclk;
  logic [2*LANES-1:0]  sh;
  logic [1:0]          fl;
  logic [LANES-1:0]    lanes;
  logic [LANES-1:0]    next_lanes;
  logic                flag;
  wire                 half      = (div == 8'(DIV - 1));
  wire                 mid       = (div == 8'(DIV / 2 - 1));   // lanes change midway between clock edges
  wire                 next_flag = lclk ? fl[1] : fl[0];
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div      <= '0;
      lclk     <= 1'b0;
      sh       <= '0;
      fl       <= '0;
      lanes    <= '0;
      flag     <= 1'b0;
      TX_READY <= 1'b0;
    end else begin
      div      <= half ? '0 : div + 1'b1;
      TX_READY <= 1'b0;
      if (mid) begin
        lanes <= next_lanes;
        flag  <= next_flag;
      end
      if (half) begin
        lclk <= ~lclk;
        if (lclk) begin                                        // clock about to fall: load next word
          sh       <= TX_DATA;
          fl       <= TX_FLAGS;
          TX_READY <= 1'b1;
        end
      end
    end
  end
  // each byte gets its own clock; low half sent for the rise, high half for the fall
  assign LINK.cmd_addr_data_lanes = lanes;
  genvar g;
  generate
    for (g = 0; g < SUBS; g++) begin : g_tx
      localparam int W = (LANES < SUBLINK_LANES) ? LANES : SUBLINK_LANES;
      assign LINK.link_clk[g] = lclk;
      assign next_lanes[g*W +: W] = lclk ? sh[2*g*W+W +: W] : sh[2*g*W +: W];
      assign LINK.control_flag_lane[g] = (THIRD_GENERATION || g == 0) ? flag : 1'b0;
    end
  endgenerate
endmodule // lsb_peer

// ---- test/lsb_link_checker.sv ----
// checker: assertions on the forwarded link clock and sideband wires joining the two ends
`timescale 1ns/1ps
module lsb_link_checker
  import lsb_pkg::*;
#(
  parameter int SUBS = 1
) (
  input wire logic            CLK,
  input wire logic            RST_N,
  input wire logic [SUBS-1:0] link_clk,
  input wire logic            power_good,
  input wire logic            link_stop_n,
  input wire logic            dev_rst_o,
  input wire logic            dev_rst_oe_n,
  input wire logic            dev_pg_o,
  input wire logic            dev_pg_oe_n,
  input wire logic            dev_req_o,
  input wire logic            dev_req_oe_n,
  input wire logic            sys_req_o,
  input wire logic            sys_req_oe_n,
  input wire logic            chain_reset_n,
  input wire logic            power_good_w,
  input wire logic            link_request_n
);
  // ****************************************
  // open-drain drives and wire relations
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  rst_pull_low_a: assert property (!dev_rst_oe_n |-> !dev_rst_o)
    else $error("device drove chain reset high");
  pg_pull_low_a: assert property (!dev_pg_oe_n |-> !dev_pg_o)
    else $error("device drove power good high");
  dev_req_low_a: assert property (!dev_req_oe_n |-> !dev_req_o)
    else $error("device drove link request high");
  sys_req_low_a: assert property (!sys_req_oe_n |-> !sys_req_o)
    else $error("system drove link request high");
  req_wired_a: assert property ((!dev_req_oe_n || !sys_req_oe_n) |-> !link_request_n)
    else $error("link request not low while pulled");
  pg_common_a: assert property (dev_pg_oe_n |-> power_good_w == power_good)
    else $error("power good differs from system level");
  stop_before_rst_a: assert property ($rose(chain_reset_n) |-> link_stop_n)
    else $error("chain reset released while link stopped");
  clk_half_a: assert property ($changed(link_clk) |=> $stable(link_clk) [*7])
    else $error("link clock half period too short");
  // main scenarios reached
  cover property ($rose(chain_reset_n));
  cover property ($fell(link_stop_n) && chain_reset_n);
  cover property (!dev_req_oe_n);
  cover property (!dev_rst_oe_n);
endmodule // lsb_link_checker

// ---- test/tb_top.sv ----
// testbench: both link ends joined, sideband sequencing and word transfer
`timescale 1ns/1ps
module tb_top;
  import lsb_pkg::*;
  // ****************************************
  // stimulus, observed outputs, table
  // ****************************************
  typedef struct packed {logic [2:0] psr; lsb_state_t st; logic ck; lsb_rst_t cl;} lsb_row_t;
  logic        clk, rst_n, third_generation, pull_rst, pull_pg, dev_req, peer_req, pg, chain_rst, stop, got, rdy;
  logic [15:0] tx_data, rx_data;
  logic [1:0]  tx_flags, rx_flags;
  logic        link_en, dev_seen, rx_valid, tx_ready, peer_seen;
  lsb_rst_t    rst_class;
  lsb_state_t  state;
  int          num_errors = 0;
  int          n_compared = 0;
  // {power good, chain reset, stop} then expected state and class
  lsb_row_t rows [9] = '{'{3'b011, LSB_OFF, 1'b0, LSB_RST_NONE}, '{3'b111, LSB_RESET, 1'b1, LSB_RST_COLD},
    '{3'b101, LSB_RESET, 1'b0, LSB_RST_NONE}, '{3'b100, LSB_RUN, 1'b0, LSB_RST_NONE},
    '{3'b101, LSB_STOP, 1'b0, LSB_RST_NONE}, '{3'b100, LSB_RUN, 1'b0, LSB_RST_NONE},
    '{3'b110, LSB_RESET, 1'b1, LSB_RST_WARM}, '{3'b111, LSB_RESET, 1'b0, LSB_RST_NONE},
    '{3'b001, LSB_OFF, 1'b0, LSB_RST_NONE}};
  // ****************************************
  // both ends and the checker
  // ****************************************
  lsb_if #(.LANES(8)) lsb_if_inst ();
  lsb_device #(.LANES(8), .DB_CYCLES(4)) lsb_device_inst (.CLK(clk), .RST_N(rst_n), .LINK(lsb_if_inst),
    .THIRD_GENERATION(third_generation), .PULL_RESET(pull_rst), .PULL_PG(pull_pg), .REQUEST(dev_req), .LINK_ENABLE(link_en),
    .LINK_REQ_SEEN(dev_seen), .RESET_CLASS(rst_class), .STATE(state), .RX_DATA(rx_data),
    .RX_FLAGS(rx_flags), .RX_VALID(rx_valid));
  lsb_peer lsb_peer_inst (.CLK(clk), .RST_N(rst_n), .LINK(lsb_if_inst), .THIRD_GENERATION(third_generation),
    .POWER_GOOD(pg), .CHAIN_RESET(chain_rst), .STOP(stop), .REQUEST(peer_req), .TX_DATA(tx_data),
    .TX_FLAGS(tx_flags), .TX_READY(tx_ready), .REQ_SEEN(peer_seen));
  lsb_link_checker #(.SUBS(1)) lsb_link_checker_inst (.CLK(clk), .RST_N(rst_n),
    .link_clk(lsb_if_inst.link_clk), .power_good(lsb_if_inst.power_good),
    .link_stop_n(lsb_if_inst.link_stop_n), .dev_rst_o(lsb_if_inst.dev_rst_o),
    .dev_rst_oe_n(lsb_if_inst.dev_rst_oe_n), .dev_pg_o(lsb_if_inst.dev_pg_o),
    .dev_pg_oe_n(lsb_if_inst.dev_pg_oe_n), .dev_req_o(lsb_if_inst.dev_req_o),
    .dev_req_oe_n(lsb_if_inst.dev_req_oe_n), .sys_req_o(lsb_if_inst.sys_req_o),
    .sys_req_oe_n(lsb_if_inst.sys_req_oe_n), .chain_reset_n(lsb_if_inst.chain_reset_n),
    .power_good_w(lsb_if_inst.power_good_w), .link_request_n(lsb_if_inst.link_request_n));
  // ****************************************
  // helpers
  // ****************************************
  // wait n edges, then settle at the falling edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic chk(input logic [15:0] gv, input logic [15:0] ev);
    n_compared++;
    if (gv !== ev) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, gv, ev);
    end
  endtask
  task automatic side(input logic [2:0] v);
    @(posedge clk);
    {pg, chain_rst, stop} <= v;
    cyc(40);
  endtask
  // look for one received word within four link periods
  task automatic wait_valid(output logic seen);
    seen = 1'b0;
    for (int w = 0; w < 64 && !seen; w++) begin
      @(negedge clk);
      seen = (rx_valid === 1'b1);
    end
  endtask
  task automatic conclude();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ****************************************
  // clock, watchdog, sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    conclude();
  end
  initial begin
    {third_generation, pull_rst, pull_pg, dev_req, peer_req, rst_n} = '0;
    {pg, chain_rst, stop} = 3'b011;
    tx_data = 16'h0;
    tx_flags = 2'h0;
    cyc(12);
    @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      side(rows[i].psr);
      chk(state, rows[i].st);
      chk(link_en, rows[i].st == LSB_RUN);
      if (rows[i].ck) chk(rst_class, rows[i].cl);
    end
    side(3'b110);
    side(3'b100);
    // short stop glitch is filtered
    @(posedge clk);
    stop <= 1'b1;
    repeat (2) @(posedge clk);
    stop <= 1'b0;
    cyc(40);
    chk(state, LSB_RUN);
    // either end pulls link request, both see it
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      dev_req <= (k == 0);
      peer_req <= (k == 1);
      cyc(40);
      chk(dev_seen, k < 2);
      chk(peer_seen, k < 2);
    end
    // words cross the link, then are dropped while stopped
    for (int j = 0; j < 2; j++) begin
      @(posedge clk);
      tx_data <= j ? 16'h5a0f : 16'h12c3;
      tx_flags <= j ? 2'h1 : 2'h2;
      rdy = 1'b0;
      repeat (40) begin
        @(negedge clk);
        rdy = rdy | (tx_ready === 1'b1);
      end
      chk(rdy, 1'b1);
      wait_valid(got);
      chk(got, 1'b1);
      // rising-edge bits land in the upper half of each sublink's word
      chk(rx_data, {tx_data[7:0], tx_data[15:8]});
      chk(rx_flags, {tx_flags[0], tx_flags[1]});
    end
    side(3'b101);
    wait_valid(got);
    chk(got, 1'b0);
    side(3'b100);
    // device pulls low only in first generation
    for (int g = 0; g < 2; g++) begin
      @(posedge clk);
      third_generation <= g;
      pull_rst <= 1'b1;
      pull_pg <= 1'b1;
      cyc(4);
      chk(lsb_if_inst.chain_reset_n, g);
      chk(lsb_if_inst.power_good_w, g);
      @(posedge clk);
      {pull_rst, pull_pg} <= 2'b00;
      side(3'b110);
      side(3'b100);
      chk(state, LSB_RUN);
    end
    // second reset in mid-run
    @(posedge clk);
    rst_n <= 1'b0;
    cyc(2);
    chk(state, LSB_OFF);
    chk(link_en, 1'b0);
    chk(rst_class, LSB_RST_NONE);
    @(posedge clk);
    rst_n <= 1'b1;
    cyc(2);
    chk(state, LSB_OFF);
    chk(dev_seen, 1'b0);
    chk(peer_seen, 1'b0);
    conclude();
  end
endmodule // tb_top
